//--- logic/scs_pkg.sv
// constants, types and helpers shared by the management bus slave
package scs_pkg;
    localparam int          PORT_W       = 2;
    localparam int          OFS_W        = 8;
    localparam int          MEM_AW       = PORT_W + OFS_W;
    localparam int          MEM_DEPTH    = 1 << MEM_AW;
    localparam logic [3:0]  ADDR_FIXED   = 4'hd;   // address bits 6..3 = 1,1,0,1
    localparam logic [3:0]  BYTE_BITS    = 4'h8;
    localparam logic [7:0]  HDR_TYPE_OFS = 8'h0e;
    localparam logic [7:0]  HDR_TYPE1    = 8'h01;
    localparam logic [1:0]  LAST_BIDX    = 2'h3;
    // register type regions of each port's configuration space
    localparam logic [7:0]  RG_W1C_LO    = 8'h60;
    localparam logic [7:0]  RG_W1CS_LO   = 8'h70;
    localparam logic [7:0]  RG_RWS_LO    = 8'h80;
    localparam logic [7:0]  RG_ROS_LO    = 8'h90;
    localparam logic [7:0]  RG_HWI_LO    = 8'ha0;
    localparam logic [7:0]  RG_RW_LO     = 8'hb0;

    typedef enum logic [2:0] {
        RT_RW, RT_W1C, RT_W1C_S, RT_RW_S, RT_RO_S, RT_HWI
    } scs_rtype_t;

    function automatic logic [6:0] slave_addr(input logic [2:0] strap);
        slave_addr = {ADDR_FIXED, strap[2], strap[1], strap[0]};
    endfunction

    function automatic scs_rtype_t rtype(input logic [7:0] ofs);
        if (ofs >= RG_RW_LO)        rtype = RT_RW;
        else if (ofs >= RG_HWI_LO)  rtype = RT_HWI;
        else if (ofs >= RG_ROS_LO)  rtype = RT_RO_S;
        else if (ofs >= RG_RWS_LO)  rtype = RT_RW_S;
        else if (ofs >= RG_W1CS_LO) rtype = RT_W1C_S;
        else if (ofs >= RG_W1C_LO)  rtype = RT_W1C;
        else                        rtype = RT_RW;
    endfunction

    // value stored by a bus write; preloadable read-only kinds stay writable from the bus
    function automatic logic [7:0] apply_wr(input scs_rtype_t rt, input logic [7:0] old, input logic [7:0] wd);
        case (rt)
            RT_W1C, RT_W1C_S: apply_wr = old & ~wd;
            default:          apply_wr = wd;
        endcase
    endfunction
endpackage

//--- logic/scs_mem_if.sv
// carrier between the transaction engine and the configuration store
interface scs_mem_if;
    import scs_pkg::*;
    logic [MEM_AW-1:0] addr;
    logic              we;
    logic [7:0]        wdata;
    logic [7:0]        rdata;
    modport mem (input addr, input we, input wdata, output rdata);
    modport ctl (output addr, output we, output wdata, input rdata);
endinterface

//--- logic/scs_cfg_mem.sv
// byte-wide configuration store for all four ports, registered read
module scs_cfg_mem (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic ce,
    scs_mem_if.mem    m
);
    import scs_pkg::*;
    logic [7:0] ram [0:MEM_DEPTH-1];
    logic [7:0] rdata_r;

    always_ff @(posedge clk_sys) begin
        if (ce && m.we) begin
            ram[m.addr] <= m.wdata;
        end
    end

    // read returns the value before a same-cycle write
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= ram[m.addr];
        end
    end

    assign m.rdata = rdata_r;
endmodule

//--- logic/scs_slave.sv
// management bus slave giving a master access to the per-port configuration space
// Function
// R1 - act only as bus slave; accept writes and return read data
// R2 - every read/write configuration register is readable and writable over the bus
// R3 - preloadable read-only and hardware-initialized registers are also bus writable
// R4 - slave address bits 2..0 come from the three strap pins in order
// R5 - address bits 3,5,6 are one, bit 4 zero; respond only to that address
// R6 - clock and data lines are open lines either side may pull low
// R7 - write-one-to-clear bits read current value; writing one clears the bit
// R8 - support sticky clear-on-one, sticky read/write and sticky read-only bits
// R9 - each port shows a type 1 bridge header reachable over the bus
// R10 - foreign address byte gets no acknowledge and both lines stay released
module scs_slave (
    input  wire logic                       clk_sys,
    input  wire logic                       rst_n,
    input  wire logic                       ce,
    input  wire logic                       link_clk,
    input  wire logic                       mgmt_clock_pin_i,
    output logic                            mgmt_clock_pin_o,
    output logic                            mgmt_clock_pin_oe,
    input  wire logic                       mgmt_data_pin_i,
    output logic                            mgmt_data_pin_o,
    output logic                            mgmt_data_pin_oe,
    input  wire logic [2:0]                 addr_strap,
    input  wire logic                       evt_valid,
    input  wire logic [scs_pkg::PORT_W-1:0] evt_port,
    input  wire logic [scs_pkg::OFS_W-1:0]  evt_ofs,
    input  wire logic [7:0]                 evt_bits,
    output logic                            evt_done
);
    import scs_pkg::*;

    typedef enum logic [2:0] {L_IDLE, L_RX, L_ACK, L_WAIT, L_TX, L_MACK} scs_lst_t;
    typedef enum logic [1:0] {S_IDLE, S_RD, S_WR} scs_sst_t;

    typedef struct packed {
        logic              scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;
        logic [2:0]        strap_m, strap_s;
        logic              ce_m, ce_s, ack_m, ack_s;
        scs_lst_t          st;
        logic [1:0]        bidx;
        logic              rd;
        logic [3:0]        bitcnt;
        logic [7:0]        shreg;
        logic              sda_drv, scl_drv, pin_lo;
        logic [PORT_W-1:0] port;
        logic [OFS_W-1:0]  ofs;
        logic              req_tg, req_we;
        logic [PORT_W-1:0] req_port;
        logic [OFS_W-1:0]  req_ofs;
        logic [7:0]        req_wdata;
    } scs_lnk_t;

    typedef struct packed {
        logic              req_m, req_s, req_p;
        scs_sst_t          st;
        logic              ack_tg;
        logic [7:0]        rdata;
        logic              evt_done;
        logic              op_evt, op_we;
        logic [MEM_AW-1:0] op_addr;
        logic [7:0]        op_wdata;
    } scs_sys_t;

    scs_lnk_t  l_r, l_nxt;
    scs_sys_t  s_r, s_nxt;
    scs_mem_if mif ();

    scs_cfg_mem u_mem (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .ce      (ce),
        .m       (mif.mem)
    );

    // ---------------- link side, runs on the bus oversampling clock
    logic       scl_rise, scl_fall, bus_start, bus_stop, pend, own_addr;
    logic [6:0] my_addr;

    assign scl_rise  = l_r.scl_s & ~l_r.scl_p;
    assign scl_fall  = ~l_r.scl_s & l_r.scl_p;
    assign bus_start = l_r.scl_s & l_r.scl_p & l_r.sda_p & ~l_r.sda_s;
    assign bus_stop  = l_r.scl_s & l_r.scl_p & ~l_r.sda_p & l_r.sda_s;
    assign pend      = l_r.req_tg ^ l_r.ack_s;
    assign my_addr   = slave_addr(l_r.strap_s);            // [R4]
    assign own_addr  = (l_r.shreg[7:1] == my_addr);         // [R5]

    always_comb begin
        l_nxt         = l_r;
        l_nxt.scl_m   = mgmt_clock_pin_i;
        l_nxt.scl_s   = l_r.scl_m;
        l_nxt.scl_p   = l_r.scl_s;
        l_nxt.sda_m   = mgmt_data_pin_i;
        l_nxt.sda_s   = l_r.sda_m;
        l_nxt.sda_p   = l_r.sda_s;
        l_nxt.strap_m = addr_strap;
        l_nxt.strap_s = l_r.strap_m;
        l_nxt.ce_m    = ce;
        l_nxt.ce_s    = l_r.ce_m;
        l_nxt.ack_m   = s_r.ack_tg;
        l_nxt.ack_s   = l_r.ack_m;
        if (l_r.ce_s) begin
            if (bus_start) begin
                l_nxt.st      = L_RX;
                l_nxt.bidx    = 2'h0;
                l_nxt.bitcnt  = 4'h0;
                l_nxt.sda_drv = 1'b0;
                l_nxt.scl_drv = 1'b0;
            end else if (bus_stop) begin
                l_nxt.st      = L_IDLE;
                l_nxt.sda_drv = 1'b0;
                l_nxt.scl_drv = 1'b0;
            end else begin
                case (l_r.st)
                    L_RX: begin
                        if (scl_rise && l_r.bitcnt != BYTE_BITS) begin
                            l_nxt.shreg  = {l_r.shreg[6:0], l_r.sda_s};
                            l_nxt.bitcnt = l_r.bitcnt + 4'h1;
                        end else if (scl_fall && l_r.bitcnt == BYTE_BITS) begin
                            l_nxt.bitcnt  = 4'h0;
                            l_nxt.st      = L_ACK;
                            l_nxt.sda_drv = 1'b1;               // [R1]
                            case (l_r.bidx)
                                2'h0: begin
                                    if (!own_addr) begin
                                        l_nxt.st      = L_IDLE; // [R10]
                                        l_nxt.sda_drv = 1'b0;
                                    end else begin
                                        l_nxt.rd = l_r.shreg[0];
                                        if (l_r.shreg[0]) begin
                                            l_nxt.req_tg   = ~l_r.req_tg;
                                            l_nxt.req_we   = 1'b0;
                                            l_nxt.req_port = l_r.port;
                                            l_nxt.req_ofs  = l_r.ofs;
                                        end
                                    end
                                end
                                2'h1: l_nxt.port = l_r.shreg[PORT_W-1:0];
                                2'h2: l_nxt.ofs  = l_r.shreg;
                                default: begin
                                    l_nxt.req_tg    = ~l_r.req_tg;  // [R2]
                                    l_nxt.req_we    = 1'b1;
                                    l_nxt.req_port  = l_r.port;
                                    l_nxt.req_ofs   = l_r.ofs;
                                    l_nxt.req_wdata = l_r.shreg;
                                    l_nxt.ofs       = l_r.ofs + 8'h01;
                                end
                            endcase
                        end
                    end
                    L_ACK: begin
                        if (scl_fall) begin
                            l_nxt.sda_drv = 1'b0;
                            if (l_r.rd && pend) begin
                                // hold the clock low until the read word is back
                                l_nxt.scl_drv = 1'b1;           // [R6]
                                l_nxt.st      = L_WAIT;
                            end else if (l_r.rd) begin
                                l_nxt.shreg   = s_r.rdata;
                                l_nxt.sda_drv = ~s_r.rdata[7];
                                l_nxt.bitcnt  = 4'h1;
                                l_nxt.st      = L_TX;
                            end else begin
                                l_nxt.st = L_RX;
                                if (l_r.bidx != LAST_BIDX) begin
                                    l_nxt.bidx = l_r.bidx + 2'h1;
                                end
                            end
                        end
                    end
                    L_WAIT: begin
                        if (!pend) begin
                            l_nxt.scl_drv = 1'b0;
                            l_nxt.shreg   = s_r.rdata;
                            l_nxt.sda_drv = ~s_r.rdata[7];
                            l_nxt.bitcnt  = 4'h1;
                            l_nxt.st      = L_TX;
                        end
                    end
                    L_TX: begin
                        if (scl_fall && l_r.bitcnt == BYTE_BITS) begin
                            l_nxt.sda_drv = 1'b0;
                            l_nxt.st      = L_MACK;
                        end else if (scl_fall) begin
                            l_nxt.shreg   = {l_r.shreg[6:0], 1'b0};
                            l_nxt.sda_drv = ~l_r.shreg[6];      // [R1]
                            l_nxt.bitcnt  = l_r.bitcnt + 4'h1;
                        end
                    end
                    L_MACK: begin
                        if (scl_rise && !l_r.sda_s) begin
                            l_nxt.ofs      = l_r.ofs + 8'h01;
                            l_nxt.req_tg   = ~l_r.req_tg;
                            l_nxt.req_we   = 1'b0;
                            l_nxt.req_port = l_r.port;
                            l_nxt.req_ofs  = l_r.ofs + 8'h01;
                            l_nxt.st       = L_ACK;
                        end else if (scl_rise) begin
                            l_nxt.st = L_IDLE;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            l_r <= '{st: L_IDLE, default: '0};
        end else begin
            l_r <= l_nxt;
        end
    end

    // pins only ever pull low, never drive high
    assign mgmt_clock_pin_o  = l_r.pin_lo;
    assign mgmt_data_pin_o   = l_r.pin_lo;
    assign mgmt_clock_pin_oe = l_r.scl_drv;                    // [R6]
    assign mgmt_data_pin_oe  = l_r.sda_drv;                    // [R6]

    // ---------------- system side: read-modify-write of the store
    logic       evt_hit, merge;
    scs_rtype_t op_rt;
    logic [7:0] wr_val;

    assign evt_hit = evt_valid & ~s_r.evt_done & (s_r.op_addr == {evt_port, evt_ofs});
    assign merge   = (s_r.st == S_WR) & ~s_r.op_evt & evt_hit;
    assign op_rt   = rtype(s_r.op_addr[OFS_W-1:0]);           // [R8]

    always_comb begin
        // a hardware set landing on a clearing write wins
        if (s_r.op_evt) begin
            wr_val = mif.rdata | s_r.op_wdata;
        end else if (s_r.op_we) begin
            wr_val = apply_wr(op_rt, mif.rdata, s_r.op_wdata) | (merge ? evt_bits : 8'h00);  // [R7]
        end else begin
            // a set merged into a bus read must still land, or it is lost
            wr_val = mif.rdata | evt_bits;
        end
    end

    assign mif.addr  = s_r.op_addr;
    assign mif.wdata = wr_val;
    // header type byte is fixed, so writes to it are dropped
    assign mif.we    = (s_r.st == S_WR) & (s_r.op_evt | s_r.op_we | merge)
                       & (s_r.op_addr[OFS_W-1:0] != HDR_TYPE_OFS);   // [R3]

    always_comb begin
        s_nxt          = s_r;
        s_nxt.req_m    = l_r.req_tg;
        s_nxt.req_s    = s_r.req_m;
        s_nxt.evt_done = 1'b0;
        case (s_r.st)
            S_IDLE: begin
                if (s_r.req_s != s_r.req_p) begin
                    // request word is held steady by the link until answered
                    s_nxt.req_p    = s_r.req_s;
                    s_nxt.op_addr  = {l_r.req_port, l_r.req_ofs};
                    s_nxt.op_we    = l_r.req_we;
                    s_nxt.op_wdata = l_r.req_wdata;
                    s_nxt.op_evt   = 1'b0;
                    s_nxt.st       = S_RD;
                end else if (evt_valid && !s_r.evt_done) begin
                    s_nxt.op_addr  = {evt_port, evt_ofs};
                    s_nxt.op_wdata = evt_bits;
                    s_nxt.op_evt   = 1'b1;
                    s_nxt.st       = S_RD;
                end
            end
            S_RD: s_nxt.st = S_WR;
            S_WR: begin
                s_nxt.st = S_IDLE;
                if (s_r.op_evt || merge) begin
                    s_nxt.evt_done = 1'b1;
                end
                if (!s_r.op_evt) begin
                    s_nxt.rdata  = (s_r.op_addr[OFS_W-1:0] == HDR_TYPE_OFS) ? HDR_TYPE1 : mif.rdata;  // [R9]
                    s_nxt.ack_tg = ~s_r.ack_tg;
                end
            end
            default: s_nxt.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '{st: S_IDLE, default: '0};
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign evt_done = s_r.evt_done;

    // ---------------- checks
    property p_nack_foreign;
        @(posedge link_clk) disable iff (!rst_n)
        (l_r.ce_s && !bus_start && !bus_stop && l_r.st == L_RX && scl_fall && l_r.bitcnt == BYTE_BITS
         && l_r.bidx == 2'h0 && !own_addr) |=> (l_r.st == L_IDLE && !l_r.sda_drv && !l_r.scl_drv);
    endproperty
    a_nack_foreign: assert property (p_nack_foreign) else $error("foreign address was acknowledged"); // [R10]

    property p_ack_own;
        @(posedge link_clk) disable iff (!rst_n)
        (l_r.ce_s && !bus_start && !bus_stop && l_r.st == L_RX && scl_fall && l_r.bitcnt == BYTE_BITS
         && l_r.bidx == 2'h0 && own_addr) |=> (l_r.st == L_ACK && l_r.sda_drv);
    endproperty
    a_ack_own: assert property (p_ack_own) else $error("own address not acknowledged"); // [R5]

    property p_strap_map;
        @(posedge link_clk) disable iff (!rst_n)
        my_addr[2:0] == l_r.strap_s && my_addr[6:3] == 4'hd;
    endproperty
    a_strap_map: assert property (p_strap_map) else $error("slave address composed wrongly"); // [R4]

    property p_open_lines;
        @(posedge link_clk) disable iff (!rst_n)
        (l_r.sda_drv |-> (l_r.st == L_ACK || l_r.st == L_TX)) and (l_r.scl_drv |-> l_r.st == L_WAIT)
        and !mgmt_data_pin_o;
    endproperty
    a_open_lines: assert property (p_open_lines) else $error("line pulled outside its slot"); // [R6]

    property p_answer;
        @(posedge clk_sys) disable iff (!rst_n || !ce)
        (s_r.st == S_IDLE && s_r.req_s != s_r.req_p) |-> ##3 $changed(s_r.ack_tg);
    endproperty
    a_answer: assert property (p_answer) else $error("link request not answered in three cycles"); // [R1]

    property p_rw_store;
        @(posedge clk_sys) disable iff (!rst_n || !ce)
        (s_r.st == S_WR && s_r.op_we && !s_r.op_evt && !merge && s_r.op_addr[OFS_W-1:0] != HDR_TYPE_OFS
         && (op_rt == RT_RW || op_rt == RT_RW_S)) |-> (mif.we && mif.wdata == s_r.op_wdata);
    endproperty
    a_rw_store: assert property (p_rw_store) else $error("read/write byte not stored"); // [R2]

    property p_preload_store;
        @(posedge clk_sys) disable iff (!rst_n || !ce)
        (s_r.st == S_WR && s_r.op_we && !s_r.op_evt && (op_rt == RT_RO_S || op_rt == RT_HWI))
        |-> (mif.we && mif.wdata == (s_r.op_wdata | (merge ? evt_bits : 8'h00)));
    endproperty
    a_preload_store: assert property (p_preload_store) else $error("preloadable byte not writable"); // [R3]

    property p_w1c;
        @(posedge clk_sys) disable iff (!rst_n || !ce)
        (s_r.st == S_WR && s_r.op_we && !s_r.op_evt && !merge && op_rt == RT_W1C)
        |-> (mif.wdata == (mif.rdata & ~s_r.op_wdata));
    endproperty
    a_w1c: assert property (p_w1c) else $error("write-one-to-clear misbehaved"); // [R7]

    property p_sticky_w1c;
        @(posedge clk_sys) disable iff (!rst_n || !ce)
        (s_r.st == S_WR && s_r.op_we && !s_r.op_evt && merge && op_rt == RT_W1C_S)
        |-> (mif.wdata == ((mif.rdata & ~s_r.op_wdata) | evt_bits)) ##1 s_r.evt_done;
    endproperty
    a_sticky_w1c: assert property (p_sticky_w1c) else $error("set lost against sticky clear"); // [R8]

    property p_hdr_type;
        @(posedge clk_sys) disable iff (!rst_n || !ce)
        (s_r.st == S_WR && !s_r.op_evt && s_r.op_addr[OFS_W-1:0] == HDR_TYPE_OFS)
        |-> !mif.we ##1 (s_r.rdata == HDR_TYPE1);
    endproperty
    a_hdr_type: assert property (p_hdr_type) else $error("bridge header type not reported"); // [R9]
endmodule

//--- tb/scs_bus_master.sv
// bus master model pulling the two open lines of the management bus
module scs_bus_master (
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_oe,
    output logic      sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam time Q = 250;
    logic [7:0] rd_data;
    logic       ack_bit;
    event       rd_ev;
    event       ack_ev;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    // lines are only pulled low or released, never driven high
    task automatic rise();
        scl_oe = 1'b0;
        // the slave may stretch the low phase; bounded so a stuck line cannot hang us
        for (int i = 0; i < 2000 && scl !== 1'b1; i++) #10;
        #Q;
    endtask
    task automatic start();
        #Q;
        sda_oe = 1'b0;
        #Q;
        rise();
        sda_oe = 1'b1;
        #Q;
        scl_oe = 1'b1;
    endtask
    task automatic stop();
        #Q;
        sda_oe = 1'b1;
        #Q;
        rise();
        sda_oe = 1'b0;
        #Q;
    endtask
    // data changes a quarter after the fall so it never mimics start or stop
    task automatic bitx(input logic b, output logic r);
        #Q;
        sda_oe = ~b;
        #Q;
        rise();
        r = sda;
        scl_oe = 1'b1;
    endtask
    task automatic wbyte(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bitx(d[i], r);
        bitx(1'b1, ack_bit);
        ->ack_ev;
    endtask
    task automatic rbyte(input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, r);
            rd_data[i] = r;
        end
        bitx(last, r);
        ->rd_ev;
    endtask
endmodule

//--- tb/scs_slave_bench.sv
// self-checking bench for the management bus slave
module scs_slave_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import scs_pkg::*;
    localparam time Q_NS = 250;
    logic              clk_sys    = 1'b0;
    logic              link_clk   = 1'b0;
    logic              rst_n      = 1'b0;
    logic              ce         = 1'b1;
    logic [2:0]        addr_strap = 3'h0;
    logic              evt_valid  = 1'b0;
    logic [PORT_W-1:0] evt_port   = 2'h0;
    logic [OFS_W-1:0]  evt_ofs    = 8'h00;
    logic [7:0]        evt_bits   = 8'h00;
    logic              scl_oe_d, scl_o_d, sda_oe_d, sda_o_d, m_scl_oe, m_sda_oe, evt_done;
    wire logic         scl_w = !(scl_oe_d === 1'b1 || m_scl_oe === 1'b1);
    wire logic         sda_w = !(sda_oe_d === 1'b1 || m_sda_oe === 1'b1);
    wire logic [6:0]   own   = {1'b1, 1'b1, 1'b0, 1'b1, addr_strap};
    int                error_cnt = 0;
    int                cmp_count = 0;
    int                seed      = 90102;
    logic [7:0]        dq[$];
    logic              aq[$];
    logic              watch = 1'b0;
    logic              quiet = 1'b0;

    always #5 clk_sys = ~clk_sys;
    always #16 link_clk = ~link_clk;

    scs_slave dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .link_clk(link_clk),
        .mgmt_clock_pin_i(scl_w), .mgmt_clock_pin_o(scl_o_d), .mgmt_clock_pin_oe(scl_oe_d),
        .mgmt_data_pin_i(sda_w), .mgmt_data_pin_o(sda_o_d), .mgmt_data_pin_oe(sda_oe_d),
        .addr_strap(addr_strap), .evt_valid(evt_valid), .evt_port(evt_port),
        .evt_ofs(evt_ofs), .evt_bits(evt_bits), .evt_done(evt_done));
    scs_bus_master mst_u (.scl(scl_w), .sda(sda_w), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: byte 0x%h expected 0x%h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    always @(mst_u.rd_ev) chk_byte(mst_u.rd_data, dq.pop_front());
    always @(mst_u.ack_ev) chk_bit(mst_u.ack_bit, aq.pop_front());
    always @(posedge link_clk) if (watch && (sda_oe_d !== 1'b0 || scl_oe_d !== 1'b0)) quiet <= 1'b1;
    always @(posedge clk_sys) begin
        if (rst_n && ((scl_oe_d === 1'b1 && scl_o_d !== 1'b0) || (sda_oe_d === 1'b1 && sda_o_d !== 1'b0))) begin
            error_cnt++;
            $display("Error at %0t: line driven high", $time);
        end
    end

    task automatic put(input logic [7:0] b, input logic ea);
        aq.push_back(ea);
        mst_u.wbyte(b);
    endtask
    task automatic head(input logic [1:0] p, input logic [7:0] o);
        mst_u.start();
        put({own, 1'b0}, 1'b0);
        put({6'h00, p}, 1'b0);
        put(o, 1'b0);
    endtask
    task automatic wr(input logic [1:0] p, input logic [7:0] o, input logic [15:0] d, input int n);
        head(p, o);
        put(d[15:8], 1'b0);
        if (n > 1) put(d[7:0], 1'b0);
        mst_u.stop();
    endtask
    task automatic rd(input logic [1:0] p, input logic [7:0] o, input logic [15:0] e, input int n);
        head(p, o);
        mst_u.start();
        put({own, 1'b1}, 1'b0);
        dq.push_back(e[15:8]);
        mst_u.rbyte(n == 1);
        if (n > 1) begin
            dq.push_back(e[7:0]);
            mst_u.rbyte(1'b1);
        end
        mst_u.stop();
    endtask
    // a hardware set request; held until the one-cycle done pulse is seen
    task automatic ev(input logic [1:0] p, input logic [7:0] o, input logic [7:0] b);
        logic got;
        got = 1'b0;
        @(posedge clk_sys);
        #1;
        {evt_valid, evt_port, evt_ofs, evt_bits} = {1'b1, p, o, b};
        for (int i = 0; i < 20 && !got; i++) begin
            @(posedge clk_sys);
            #1;
            got = (evt_done === 1'b1);
        end
        evt_valid = 1'b0;
        chk_bit(got, 1'b1);
    endtask

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // about 120 bytes at three quarter-periods a bit, some 40% above the 85 planned bytes
    initial begin
        #(120 * 9 * 3 * Q_NS);
        error_cnt++;
        end_of_test();
    end

    initial begin
        logic [15:0] d;
        logic [7:0]  tab [4];
        tab = '{RG_W1CS_LO, RG_RWS_LO, RG_ROS_LO, RG_HWI_LO};
        addr_strap = 3'($random(seed));
        repeat (6) @(posedge clk_sys);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge link_clk);
        d = 16'($random(seed));
        wr(2'h1, 8'h10, d, 2);
        rd(2'h1, 8'h10, d, 2);
        ev(2'h2, RG_W1C_LO, 8'hff);
        wr(2'h2, RG_W1C_LO, 16'h0f00, 1);
        rd(2'h2, RG_W1C_LO, 16'hf000, 1);
        // store is undefined after power-up; clear every bit of the sticky clear byte first
        wr(2'h0, RG_W1CS_LO, 16'hff00, 1);
        for (int k = 0; k < 4; k++) begin
            ev(2'h0, tab[k], 8'h3c);
            wr(2'h0, tab[k], 16'h1400, 1);
            rd(2'h0, tab[k], (k == 0) ? 16'h2800 : 16'h1400, 1);
        end
        // set raised while the clearing write is in flight; it must merge and not be lost
        fork
            wr(2'h0, RG_W1CS_LO, 16'h0800, 1);
            begin
                @(dut_u.l_r.req_tg);
                repeat (2) @(posedge clk_sys);
                ev(2'h0, RG_W1CS_LO, 8'h03);
            end
        join
        rd(2'h0, RG_W1CS_LO, 16'h2300, 1);
        wr(2'h3, HDR_TYPE_OFS, 16'h5500, 1);
        rd(2'h3, HDR_TYPE_OFS, 16'h0100, 1);
        foreach (tab[k]) if (k < 2) begin
            mst_u.start();
            watch = 1'b1;
            put({own ^ ((k == 0) ? 7'h01 : 7'h10), 1'b0}, 1'b1);
            watch = 1'b0;
            mst_u.stop();
        end
        chk_bit(quiet, 1'b0);
        addr_strap = ~addr_strap;
        repeat (6) @(posedge link_clk);
        rd(2'h1, 8'h10, d, 1);
        end_of_test();
    end
endmodule
